// File: core/sem_pkg.sv
package sem_pkg;

    // ------------------------------------------------------------
    // Sizes of the two-stage tree
    // ------------------------------------------------------------
    localparam int SEM_N_DB = 8;            // Detector boards served
    localparam int SEM_N_STAGE = 2;         // Input-stage multiplexers
    localparam int SEM_DB_PER_STAGE = 4;    // Boards behind each stage
    localparam int SEM_EVT_W = 16;          // Event data lines
    localparam int SEM_CTRL_W = 4;          // Control lines
    localparam int SEM_PROG_W = 4;          // Programming lines
    localparam int SEM_USER_W = 8;          // User lines on the bus
    localparam int SEM_XLINK_W = 16;        // Stage to stage, each way

    // ------------------------------------------------------------
    // Per-frame limits and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] SEM_ACC_MAX = 5'h10;   // Accepted per frame
    localparam logic [2:0] SEM_FWD_MAX = 3'h4;    // Forwarded per frame
    localparam logic [4:0] SEM_ACC_RST = 5'h00;
    localparam logic [2:0] SEM_FWD_RST = 3'h0;
    localparam logic [1:0] SEM_PTR_RST = 2'h0;
    localparam logic [15:0] SEM_RATE_RST = 16'h0000;
    localparam logic [2:0] SEM_SYNC_RST = 3'h0;

    // ------------------------------------------------------------
    // One event word as it travels on the board bus
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic diag;
        logic [SEM_EVT_W-1:0] data;
    } sem_evt_t;

    localparam sem_evt_t SEM_EVT_IDLE = '{valid: 1'b0, diag: 1'b0,
                                          data: 16'h0000};

endpackage : sem_pkg

// File: core/sem_mux.sv
`timescale 1ns/10ps

// Function
// - Each input stage accepts up to 16 events per frame, forwards up to 4.
// - Drop choice rotates across inputs so loss is unbiased.
// - Control traffic fans out to boards and replies fan back in.
// - Link carries clock, boundary, control, programming, event and user lines.
// - The two input stages exchange 16 lines in each direction.
// - Events are collected from up to 8 detector boards.
// - Main stage merges both input stages towards the coincidence interface.
// - Output to slot 8 uses the same bus format as the boards.
// - Main stage can insert rate words into the outgoing stream.
module sem_mux
    import sem_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic bus_clk,
    input wire logic tsb_in,
    input wire sem_evt_t db_evt [SEM_N_DB],
    input wire logic [SEM_N_DB-1:0] db_reply,
    input wire logic [SEM_CTRL_W-1:0] ctrl_dn,
    input wire logic [SEM_PROG_W-1:0] prog_dn,
    input wire logic [SEM_USER_W-1:0] user_dn,
    input wire logic [SEM_XLINK_W-1:0] xl_tx [SEM_N_STAGE],
    input wire logic diag_en,
    output logic db_clk_q,
    output logic db_tsb_q,
    output logic [SEM_CTRL_W-1:0] db_ctrl_q,
    output logic [SEM_PROG_W-1:0] db_prog_q,
    output logic [SEM_N_STAGE-1:0] reply_up_q,
    output logic [SEM_XLINK_W-1:0] xl_rx_q [SEM_N_STAGE],
    output logic ci_clk_q,
    output logic ci_tsb_q,
    output sem_evt_t ci_evt_q,
    output logic [SEM_USER_W-1:0] ci_user_q
);

    // ------------------------------------------------------------
    // Round-robin pick among the four boards of one stage
    // ------------------------------------------------------------
    function automatic logic [2:0] rr_pick(input logic [3:0] req,
                                           input logic [1:0] ptr);
        logic [1:0] idx;
        rr_pick = 3'h0;
        for (int k = 3; k >= 0; k--) begin
            idx = ptr + k[1:0];
            if (req[idx]) begin
                rr_pick = {1'b1, idx};
            end
        end
    endfunction : rr_pick

    // ------------------------------------------------------------
    // Pin synchronisers for bus clock and boundary
    // ------------------------------------------------------------
    logic [2:0] clk_s_q, clk_s_d, tsb_s_q, tsb_s_d;
    logic clk_lvl_q, clk_lvl_d, tsb_lvl_q, tsb_lvl_d;
    logic tsb_rise;

    // A change counts only once stages two and three agree
    always_comb begin
        clk_s_d = {clk_s_q[1:0], bus_clk};
        tsb_s_d = {tsb_s_q[1:0], tsb_in};
        clk_lvl_d = (clk_s_q[1] == clk_s_q[2]) ? clk_s_q[2] : clk_lvl_q;
        tsb_lvl_d = (tsb_s_q[1] == tsb_s_q[2]) ? tsb_s_q[2] : tsb_lvl_q;
        tsb_rise = tsb_lvl_d & ~tsb_lvl_q;  // Frame start
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_s_q <= SEM_SYNC_RST;
            tsb_s_q <= SEM_SYNC_RST;
            clk_lvl_q <= 1'b0;
            tsb_lvl_q <= 1'b0;
        end else begin
            clk_s_q <= clk_s_d;
            tsb_s_q <= tsb_s_d;
            clk_lvl_q <= clk_lvl_d;
            tsb_lvl_q <= tsb_lvl_d;
        end
    end

    // ------------------------------------------------------------
    // Pass-through lines: clock, boundary, control, programming
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            db_clk_q <= 1'b0;
            db_tsb_q <= 1'b0;
            ci_clk_q <= 1'b0;
            ci_tsb_q <= 1'b0;
            db_ctrl_q <= '0;
            db_prog_q <= '0;
            ci_user_q <= '0;
            reply_up_q <= '0;
        end else begin
            db_clk_q <= clk_lvl_q;
            db_tsb_q <= tsb_lvl_q;
            ci_clk_q <= clk_lvl_q;
            ci_tsb_q <= tsb_lvl_q;
            db_ctrl_q <= ctrl_dn;                  // Fan-out to all
            db_prog_q <= prog_dn;
            ci_user_q <= user_dn;
            reply_up_q <= {|db_reply[7:4], |db_reply[3:0]}; // Fan
        end
    end

    // ------------------------------------------------------------
    // Input stages: accept, cap and hold one word for the main stage
    // ------------------------------------------------------------
    logic [4:0] acc_q [SEM_N_STAGE];
    logic [2:0] fwd_q [SEM_N_STAGE];
    logic [1:0] ptr_q [SEM_N_STAGE];
    sem_evt_t hold_q [SEM_N_STAGE];
    logic [SEM_N_STAGE-1:0] take;
    logic [SEM_N_STAGE-1:0] drop_seen;

    for (genvar s = 0; s < SEM_N_STAGE; s++) begin : g_stage
        logic [3:0] req;
        logic [2:0] pick;
        logic [4:0] acc_d;
        logic [2:0] fwd_d;
        logic [1:0] ptr_d;
        sem_evt_t hold_d;
        logic [SEM_XLINK_W-1:0] xl_d;

        // Only one board per cycle is taken; pointer moves past it
        always_comb begin
            for (int b = 0; b < SEM_DB_PER_STAGE; b++) begin
                req[b] = db_evt[s*SEM_DB_PER_STAGE + b].valid;
            end
            pick = rr_pick(req, ptr_q[s]);
            acc_d = acc_q[s];
            fwd_d = fwd_q[s];
            ptr_d = ptr_q[s];
            hold_d = take[s] ? SEM_EVT_IDLE : hold_q[s];
            drop_seen[s] = 1'b0;
            xl_d = xl_tx[SEM_N_STAGE-1-s];
            if (tsb_rise) begin
                acc_d = SEM_ACC_RST;
                fwd_d = SEM_FWD_RST;
                ptr_d = ptr_q[s] + 2'h1;  // New frame, new favourite
            end else if (pick[2] && acc_q[s] < SEM_ACC_MAX) begin
                acc_d = acc_q[s] + 5'h1;
                ptr_d = pick[1:0] + 2'h1;
                if (fwd_q[s] < SEM_FWD_MAX && !hold_d.valid) begin
                    hold_d = db_evt[s*SEM_DB_PER_STAGE + 32'(pick[1:0])];
                    hold_d.diag = 1'b0;
                    fwd_d = fwd_q[s] + 3'h1;
                end else begin
                    drop_seen[s] = 1'b1;
                end
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                acc_q[s] <= SEM_ACC_RST;
                fwd_q[s] <= SEM_FWD_RST;
                ptr_q[s] <= SEM_PTR_RST;
                hold_q[s] <= SEM_EVT_IDLE;
                xl_rx_q[s] <= '0;
            end else begin
                acc_q[s] <= acc_d;
                fwd_q[s] <= fwd_d;
                ptr_q[s] <= ptr_d;
                hold_q[s] <= hold_d;
                xl_rx_q[s] <= xl_d;
            end
        end

        a_fwd_cap: assert property (@(posedge mclk)
            disable iff (!rst_n)
            fwd_q[s] <= SEM_FWD_MAX)
            else $error("more than four events forwarded in a frame");
        a_acc_cap: assert property (@(posedge mclk)
            disable iff (!rst_n)
            acc_q[s] <= SEM_ACC_MAX)
            else $error("more than sixteen events accepted in a frame");
        a_frame_restart: assert property (@(posedge mclk)
            disable iff (!rst_n)
            tsb_rise |=> acc_q[s] == SEM_ACC_RST && fwd_q[s] == SEM_FWD_RST)
            else $error("frame counters did not restart at boundary");
        a_rr_rotate: assert property (@(posedge mclk)
            disable iff (!rst_n)
            tsb_rise |=> ptr_q[s] == $past(ptr_q[s]) + 2'h1)
            else $error("priority did not rotate at frame start");
        a_hold_kept: assert property (@(posedge mclk)
            disable iff (!rst_n)
            hold_q[s].valid && !take[s] |=> hold_q[s] == $past(hold_q[s]))
            else $error("held event lost before main stage took it");
        a_xlink_pass: assert property (@(posedge mclk)
            disable iff (!rst_n)
            ##1 xl_rx_q[s] == $past(xl_tx[SEM_N_STAGE-1-s]))
            else $error("stage cross link did not carry peer data");
    end

    // ------------------------------------------------------------
    // Main stage: merge both holds, insert rate words at frame start
    // ------------------------------------------------------------
    logic mrr_q, mrr_d;
    logic pend_q, pend_d;
    logic [15:0] rate_q, rate_d, snap_q, snap_d;
    sem_evt_t out_d;

    // Rate word wins over events; it is rare and events can wait
    always_comb begin
        take = '0;
        out_d = SEM_EVT_IDLE;
        mrr_d = mrr_q;
        pend_d = pend_q;
        snap_d = snap_q;
        if (pend_q && diag_en) begin
            out_d = '{valid: 1'b1, diag: 1'b1, data: snap_q};
            pend_d = 1'b0;
        end else if (hold_q[mrr_q].valid) begin
            take[mrr_q] = 1'b1;
            out_d = hold_q[mrr_q];
            mrr_d = ~mrr_q;
        end else if (hold_q[~mrr_q].valid) begin
            take[~mrr_q] = 1'b1;
            out_d = hold_q[~mrr_q];
        end
        rate_d = rate_q + {15'h0000, out_d.valid & ~out_d.diag};
        if (tsb_rise) begin
            snap_d = rate_q;
            pend_d = 1'b1;
            rate_d = {15'h0000, out_d.valid & ~out_d.diag};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mrr_q <= 1'b0;
            pend_q <= 1'b0;
            rate_q <= SEM_RATE_RST;
            snap_q <= SEM_RATE_RST;
            ci_evt_q <= SEM_EVT_IDLE;
        end else begin
            mrr_q <= mrr_d;
            pend_q <= pend_d;
            rate_q <= rate_d;
            snap_q <= snap_d;
            ci_evt_q <= out_d;                     // Same bus format
        end
    end

    a_out_source: assert property (@(posedge mclk) disable iff (!rst_n)
        ci_evt_q.valid && !ci_evt_q.diag
            |-> $past(hold_q[0].valid || hold_q[1].valid))
        else $error("event output without a held source word");
    a_diag_insert: assert property (@(posedge mclk)
        disable iff (!rst_n)
        tsb_rise && diag_en ##1 diag_en |=> ci_evt_q.valid && ci_evt_q.diag)
        else $error("rate word not inserted after frame start");
    a_ctrl_fanout: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $changed(ctrl_dn) |=> db_ctrl_q == $past(ctrl_dn))
        else $error("control lines not fanned out to boards");

    c_diag_word: cover property (@(posedge mclk) disable iff (!rst_n)
        ci_evt_q.valid && ci_evt_q.diag);
    c_drop: cover property (@(posedge mclk) disable iff (!rst_n)
        |drop_seen);
    c_both_hold: cover property (@(posedge mclk) disable iff (!rst_n)
        hold_q[0].valid && hold_q[1].valid);

endmodule : sem_mux

// File: sim/sem_far_model.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Detector boards upstream, coincidence interface downstream
// ------------------------------------------------------------
module sem_far_model
    import sem_pkg::*;
(
    input wire logic mclk,
    output logic bus_clk,
    output logic tsb_in,
    output sem_evt_t db_evt [SEM_N_DB],
    input wire sem_evt_t ci_evt_q
);
    int n_evt = 0;
    int n_diag = 0;
    logic [15:0] last_diag = 16'h0000;
    logic [7:0] seen = 8'h00;
    logic [15:0] cal_ofs [SEM_N_DB];

    // Link clock, a fixed 0.7 ns ahead of an mclk rising edge so edges never coincide
    initial begin
        bus_clk = 1'b0;
        tsb_in = 1'b0;
        for (int i = 0; i < SEM_N_DB; i++) begin
            db_evt[i] = SEM_EVT_IDLE;
            cal_ofs[i] = 16'(i);  // Board offset table
        end
        #5.3;
        forever #16 bus_clk = ~bus_clk;
    end

    // Boundary line is a level held by the bench between calls
    task automatic set_tsb(input logic v);
        tsb_in = v;
    endtask : set_tsb

    // One word from each board in mask; released lines show the inverse
    task automatic pulse(input logic [7:0] mask, input logic [15:0] data);
        @(posedge mclk);
        #1;
        // Offset lookup answers in the cycle it is addressed
        for (int i = 0; i < SEM_N_DB; i++) begin
            db_evt[i] = '{mask[i], 1'b0, data + cal_ofs[i]};
        end
        @(posedge mclk);
        #1;
        for (int i = 0; i < SEM_N_DB; i++) begin
            db_evt[i] = '{1'b0, 1'b0, ~(data + cal_ofs[i])};
        end
    endtask : pulse

    // Receiver: counts plain words and rate words apart
    always @(posedge mclk) begin
        if (ci_evt_q.valid === 1'b1 && ci_evt_q.diag === 1'b0) begin
            n_evt <= n_evt + 1;
            seen <= seen | (8'h01 << ci_evt_q.data[2:0]);
        end
        if (ci_evt_q.valid === 1'b1 && ci_evt_q.diag === 1'b1) begin
            n_diag <= n_diag + 1;
            last_diag <= ci_evt_q.data;
        end
    end
endmodule : sem_far_model

// File: sim/sem_mux_tb.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Bench for the singles event multiplexer
// ------------------------------------------------------------
module sem_mux_tb
    import sem_pkg::*;
;
    logic mclk, rst_n, bus_clk, tsb_in, diag_en;
    sem_evt_t db_evt [SEM_N_DB];
    logic [7:0] db_reply, user_dn, ci_user_q;
    logic [3:0] ctrl_dn, prog_dn, db_ctrl_q, db_prog_q;
    logic [15:0] xl_tx [SEM_N_STAGE];
    logic [15:0] xl_rx_q [SEM_N_STAGE];
    logic db_clk_q, db_tsb_q, ci_clk_q, ci_tsb_q;
    logic [1:0] reply_up_q;
    sem_evt_t ci_evt_q;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    sem_mux i_sem_mux (.mclk(mclk), .rst_n(rst_n), .bus_clk(bus_clk),
        .tsb_in(tsb_in), .db_evt(db_evt), .db_reply(db_reply),
        .ctrl_dn(ctrl_dn), .prog_dn(prog_dn), .user_dn(user_dn),
        .xl_tx(xl_tx), .diag_en(diag_en), .db_clk_q(db_clk_q),
        .db_tsb_q(db_tsb_q), .db_ctrl_q(db_ctrl_q), .db_prog_q(db_prog_q),
        .reply_up_q(reply_up_q), .xl_rx_q(xl_rx_q), .ci_clk_q(ci_clk_q),
        .ci_tsb_q(ci_tsb_q), .ci_evt_q(ci_evt_q), .ci_user_q(ci_user_q));
    sem_far_model i_sem_far_model (.mclk(mclk), .bus_clk(bus_clk),
        .tsb_in(tsb_in), .db_evt(db_evt), .ci_evt_q(ci_evt_q));

    // 250 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Inputs always move 1 ns after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    // Boundary: filter delay, then a new frame with counters cleared
    task automatic frame;
        i_sem_far_model.set_tsb(1'b1);
        step(2);
        check("db_tsb early", 16'h0, {15'h0, db_tsb_q});
        step(3);
        check("db_tsb", 16'h1, {15'h0, db_tsb_q});
        check("ci_tsb", 16'h1, {15'h0, ci_tsb_q});
        i_sem_far_model.set_tsb(1'b0);
        step(8);
        i_sem_far_model.n_evt = 0;
    endtask : frame

    task automatic t_pass;
        ctrl_dn = 4'ha;
        prog_dn = 4'h5;
        user_dn = 8'h3c;
        xl_tx[0] = 16'h1234;
        xl_tx[1] = 16'hbeef;
        db_reply = 8'h10;
        step(1);
        check("ctrl", 16'h000a, {12'h0, db_ctrl_q});
        check("prog", 16'h0005, {12'h0, db_prog_q});
        check("user", 16'h003c, {8'h0, ci_user_q});
        check("xl_rx0", 16'hbeef, xl_rx_q[0]);
        check("xl_rx1", 16'h1234, xl_rx_q[1]);
        check("reply", 16'h0002, {14'h0, reply_up_q});
    endtask : t_pass

    // Link clock copied to both sides; sampled mid high and mid low
    task automatic t_clk;
        @(posedge bus_clk);
        step(6);
        check("db_clk high", 16'h1, {15'h0, db_clk_q});
        check("ci_clk high", 16'h1, {15'h0, ci_clk_q});
        step(4);
        check("db_clk low", 16'h0, {15'h0, db_clk_q});
        check("ci_clk low", 16'h0, {15'h0, ci_clk_q});
    endtask : t_clk

    // One word from board b reaches the slot two edges after the board drives it
    task automatic t_single(input int b);
        frame();
        i_sem_far_model.pulse(8'h01 << b, 16'h0a50);
        step(1);
        check("evt data", 16'h0a50 + 16'(b), ci_evt_q.data);
        check("evt flags", 16'h2,
              {14'h0, ci_evt_q.valid, ci_evt_q.diag});
        step(1);
        check("evt idle", 16'h0, {15'h0, ci_evt_q.valid});
    endtask : t_single

    // Six per stage offered, four per stage forwarded, in two frames
    task automatic t_limit;
        repeat (2) begin
            frame();
            repeat (6) begin
                i_sem_far_model.pulse(8'h11, 16'h0c00);
                step(3);
            end
            check("per frame", 16'h8,
                  16'(i_sem_far_model.n_evt));
        end
    endtask : t_limit

    // Four boards collide each frame; the winner must not always be one
    task automatic t_bias;
        i_sem_far_model.seen = 8'h00;
        repeat (4) begin
            frame();
            i_sem_far_model.pulse(8'h0f, 16'h0100);
            step(4);
        end
        check("boards won", 16'h1,
              16'($countones(i_sem_far_model.seen[3:0]) > 1));
    endtask : t_bias

    // Rate word of a three event frame, only once enabled
    task automatic t_rate;
        check("no rate", 16'h0, 16'(i_sem_far_model.n_diag));
        frame();
        repeat (3) begin
            i_sem_far_model.pulse(8'h04, 16'h0d00);
            step(3);
        end
        diag_en = 1'b1;
        frame();
        check("rate value", 16'h0003, i_sem_far_model.last_diag);
        check("rate words", 16'h2, 16'(i_sem_far_model.n_diag));
    endtask : t_rate

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        diag_en = 1'b0;
        ctrl_dn = 4'h0;
        prog_dn = 4'h0;
        user_dn = 8'h00;
        db_reply = 8'h00;
        xl_tx[0] = 16'h0000;
        xl_tx[1] = 16'h0000;
        repeat (20) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        step(1);
        t_pass();
        t_clk();
        t_single(0);
        t_single(5);
        t_limit();
        t_bias();
        t_rate();
        stop_test();
    end
endmodule : sem_mux_tb
